// ==== src/interrupt_cause_upper_bits.sv ====
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Upper interrupt cause bits with APB access, mask and interrupt delivery.
// ==========================================================================
// How it works
// - Receive timer expiry sets bit seven.
// - Timer expiry also flushes pending receive descriptors.
// - Finished management access sets bit nine.
// - Received configuration symbols set bit ten.
// - Configuration symbol cause only in serdes mode.
// - Physical layer interrupt sets bit twelve.
// - Physical layer cause needs its enable bit.
// - Enabled high pins set bits thirteen, fourteen.
// - Variant adds bit eleven for input pins.
// - Transmit ring threshold sets bit fifteen.
// - Small transferred packet sets bit sixteen.
// - Zero size limit never sets bit sixteen.
// - Reserved bits read zero, written zero.
// - Message mode delivers interrupts as link messages.
// - Reading the cause register clears it.
// - Writing one clears, zero keeps.
// - Enabled set cause raises the interrupt.
module interrupt_cause_upper_bits (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Event sources, one-cycle pulses unless noted.
  input  wire logic        rx_timer_expire,
  input  wire logic        mdio_done,
  input  wire logic        rx_config_word_flag,  // Level.
  input  wire logic        phy_irq,              // Level.
  input  wire logic [2:0]  software_definable_pin,
  input  wire logic [2:0]  sdp_dir_in,           // Level, high for input pins.
  input  wire logic        tx_ring_low,
  input  wire logic        rx_pkt_done,
  input  wire logic [15:0] rx_pkt_len,
  // Receive descriptor flush request.
  output logic             rx_desc_flush,
  // Interrupt pin and link message port.
  output logic             irq,
  output logic             msg_valid,
  output logic             msg_assert,
  input  wire logic        msg_ready
);

  // ========================================================================
  // State.
  // ========================================================================
  typedef struct packed {
    logic [31:0]                  cause;  // Latched causes.
    logic [31:0]                  mask;   // Mask enables.
    logic [31:0]                  ext;    // Extended control.
    logic [icause_pkg::SRP_W-1:0] srp;    // Small packet size limit.
    logic [2:0]                   cfg;    // Mode configuration.
    logic [31:0]                  rdata;  // Read data, taken in setup.
    logic                         err;    // Unmapped address seen in setup.
    logic                         flush;  // Descriptor flush pulse.
    logic                         irq;    // Interrupt pin level.
  } cause_state_t;

  cause_state_t s;          // Current state.
  cause_state_t n;          // Next state.
  logic [31:0]  impl_mask;  // Bits that exist in this mode.
  logic [31:0]  set_v;      // Hardware set requests this cycle.
  logic [31:0]  clr_v;      // Software clears this cycle.
  logic [2:0]   gp_set;     // Pin set requests.
  logic [2:0]   gp_en;      // Pin detect enables after mode gating.
  logic         srp_hit;    // Small packet qualifies.
  logic         setup;      // APB setup cycle.
  logic         access;     // APB access cycle.
  logic         var3;       // Three-pin variant selected.
  logic         msg_mode;   // Message delivery selected.
  logic         pend;       // Some enabled cause is set.

  // ========================================================================
  // Helpers.
  // ========================================================================
  // Places one event at its cause position.
  function automatic logic [31:0] place(input int pos, input logic v);
    place = 32'(v) << pos;
  endfunction

  // Returns {hit, data} for a register read at the given address.
  function automatic logic [32:0] read_word(input logic [11:0] addr,
                                            input cause_state_t st,
                                            input logic [31:0] impl);
    if (addr == icause_pkg::CAUSE_OFF) begin
      read_word = {1'b1, st.cause & impl};
    end else if (addr == icause_pkg::MASK_OFF) begin
      read_word = {1'b1, st.mask};
    end else if (addr == icause_pkg::EXT_CTRL_OFF) begin
      read_word = {1'b1, st.ext};
    end else if (addr == icause_pkg::SRP_OFF) begin
      read_word = {1'b1, 20'h0_0000, st.srp};
    end else if (addr == icause_pkg::CFG_OFF) begin
      read_word = {1'b1, 29'h0000_0000, st.cfg};
    end else begin
      read_word = {1'b0, 32'h0000_0000};
    end
  endfunction

  // ========================================================================
  // Mode decode and event collection.
  // ========================================================================
  assign setup    = psel && !penable;
  assign access   = psel && penable;
  assign var3     = s.cfg[icause_pkg::CFG_VAR3_BIT];
  assign msg_mode = s.cfg[icause_pkg::CFG_MSG_BIT];
  assign impl_mask = var3 ? icause_pkg::CAUSE_MASK_VAR : icause_pkg::CAUSE_MASK_BASE;

  // The variant only watches pins that are configured as inputs.
  assign gp_en[0] = s.ext[icause_pkg::EXT_GPI_EN_LSB] && (!var3 || sdp_dir_in[0]);
  assign gp_en[1] = s.ext[icause_pkg::EXT_GPI_EN_LSB+1] && (!var3 || sdp_dir_in[1]);
  assign gp_en[2] = s.ext[icause_pkg::EXT_GPI_EN_LSB+2] && var3 && sdp_dir_in[2];

  // A zero limit disables the small packet cause entirely.
  assign srp_hit = rx_pkt_done && (s.srp != '0)
                && (rx_pkt_len <= {4'h0, s.srp});

  // Every source lands on its own bit; reserved positions stay clear.
  assign set_v = impl_mask & (
      place(icause_pkg::RXT_BIT, rx_timer_expire)
    | place(icause_pkg::MGMT_ACCESS_DONE_CAUSE_BIT, mdio_done)
    | place(icause_pkg::CFGS_BIT, rx_config_word_flag
            && s.cfg[icause_pkg::CFG_SERDES_BIT])
    | place(icause_pkg::PHY_BIT, phy_irq
            && s.ext[icause_pkg::EXT_PHY_EN_BIT])
    | place(icause_pkg::GPA_BIT, gp_set[0])
    | place(icause_pkg::GPB_BIT, gp_set[1])
    | place(icause_pkg::GPC_BIT, gp_set[2])
    | place(icause_pkg::TXLOW_BIT, tx_ring_low)
    | place(icause_pkg::SRP_BIT, srp_hit));

  // A read clears exactly what it returned, so an event latched after the
  // setup cycle survives; a write clears the bits written with one.
  always_comb begin
    clr_v = 32'h0000_0000;
    if (access && (paddr == icause_pkg::CAUSE_OFF)) begin
      if (pwrite) begin
        clr_v = pwdata;
      end else begin
        clr_v = s.rdata;
      end
    end
  end

  // ========================================================================
  // Next state: causes, registers, bus capture and interrupt level.
  // ========================================================================
  always_comb begin
    n       = s;
    n.cause = (s.cause & ~clr_v) | set_v;
    n.flush = rx_timer_expire;
    // Read data and error are captured in setup and held through access.
    if (setup) begin
      {n.err, n.rdata} = read_word(paddr, s, impl_mask);
      n.err = !n.err;
    end
    // Register writes take effect at the access edge.
    if (access && pwrite) begin
      if (paddr == icause_pkg::MASK_OFF) begin
        n.mask = pwdata & icause_pkg::CAUSE_MASK_VAR;
      end else if (paddr == icause_pkg::EXT_CTRL_OFF) begin
        n.ext = pwdata & icause_pkg::EXT_WMASK;
      end else if (paddr == icause_pkg::SRP_OFF) begin
        n.srp = pwdata[icause_pkg::SRP_W-1:0];
      end else if (paddr == icause_pkg::CFG_OFF) begin
        n.cfg = pwdata[2:0];
      end
    end
    // The pin stays low while messages carry the interrupt.
    n.irq = pend && !msg_mode;
  end

  // Register the whole state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // ========================================================================
  // Outputs and sub-blocks.
  // ========================================================================
  assign pend          = |(s.cause & s.mask & impl_mask);
  assign prdata        = s.rdata;
  assign pready        = access;
  assign pslverr       = access && s.err;
  assign rx_desc_flush = s.flush;
  assign irq           = s.irq;

  // Pin sampling.
  gp_pin_detect u_gp (
    .pclk      (pclk),
    .presetn   (presetn),
    .pin       (software_definable_pin),
    .detect_en (gp_en),
    .pin_set   (gp_set)
  );

  // Message delivery of the interrupt level.
  irq_msg u_msg (
    .pclk       (pclk),
    .presetn    (presetn),
    .level      (pend && msg_mode),
    .msg_valid  (msg_valid),
    .msg_assert (msg_assert),
    .msg_ready  (msg_ready)
  );

  // ========================================================================
  // Checks.
  // ========================================================================
  rxt_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    rx_timer_expire |=> s.cause[icause_pkg::RXT_BIT])
    else $error("Receive timer cause not set.");

  flush_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    rx_desc_flush == $past(rx_timer_expire))
    else $error("Flush does not follow timer expiry.");

  mgmt_access_done_cause_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    mdio_done |=> s.cause[icause_pkg::MGMT_ACCESS_DONE_CAUSE_BIT])
    else $error("Management done cause not set.");

  cfg_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    !s.cfg[icause_pkg::CFG_SERDES_BIT] && !s.cause[icause_pkg::CFGS_BIT]
    |=> !s.cause[icause_pkg::CFGS_BIT])
    else $error("Configuration cause set outside serdes mode.");

  phy_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    !s.ext[icause_pkg::EXT_PHY_EN_BIT] && !s.cause[icause_pkg::PHY_BIT]
    |=> !s.cause[icause_pkg::PHY_BIT])
    else $error("Physical layer cause set while disabled.");

  srp_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s.srp == '0) && !s.cause[icause_pkg::SRP_BIT] |=> !s.cause[icause_pkg::SRP_BIT])
    else $error("Small packet cause set with zero limit.");

  reserved_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    s.cause[8] == 1'b0 && s.cause[31:17] == 15'h0000)
    else $error("Reserved cause bit set.");

  read_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    access && !pwrite && (paddr == icause_pkg::CAUSE_OFF)
    |=> (s.cause & $past(s.rdata) & ~$past(set_v)) == 32'h0000_0000)
    else $error("Cause read did not clear returned bits.");

  write_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    access && pwrite && (paddr == icause_pkg::CAUSE_OFF)
    |=> ((s.cause & $past(pwdata) & ~$past(set_v)) == 32'h0000_0000)
        && ((s.cause & ~$past(pwdata))
            == (($past(s.cause) | $past(set_v)) & ~$past(pwdata))))
    else $error("Write-one-to-clear misbehaved.");

  event_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
    set_v != 32'h0000_0000 |=> (s.cause & $past(set_v)) == $past(set_v))
    else $error("Event lost against a clear.");

  irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 irq == ($past(pend) && !$past(msg_mode)))
    else $error("Interrupt pin does not follow enabled causes.");

endmodule
`default_nettype wire

// ==== inc/icause_pkg.sv ====
// ==========================================================================
// Shared constants for the upper interrupt cause block.
// ==========================================================================
package icause_pkg;

  // ========================================================================
  // Register byte offsets on the APB.
  // ========================================================================
  localparam logic [11:0] CAUSE_OFF    = 12'h0c0;  // Interrupt cause, read clears.
  localparam logic [11:0] EXT_CTRL_OFF = 12'h018;  // Extended control.
  localparam logic [11:0] MASK_OFF     = 12'h0d0;  // Interrupt mask enables.
  localparam logic [11:0] SRP_OFF      = 12'h100;  // Small packet size limit.
  localparam logic [11:0] CFG_OFF      = 12'h104;  // Mode configuration.

  // ========================================================================
  // Cause bit positions.
  // ========================================================================
  localparam int RXT_BIT   = 7;   // Receive timer expired.
  localparam int MGMT_ACCESS_DONE_CAUSE_BIT  = 9;   // Management access done.
  localparam int CFGS_BIT  = 10;  // Configuration symbols received.
  localparam int GPC_BIT   = 11;  // Third pin cause, three-pin variant only.
  localparam int PHY_BIT   = 12;  // Physical layer interrupt.
  localparam int GPA_BIT   = 13;  // First general purpose pin.
  localparam int GPB_BIT   = 14;  // Second general purpose pin.
  localparam int TXLOW_BIT = 15;  // Transmit ring low threshold.
  localparam int SRP_BIT   = 16;  // Small receive packet.

  // Implemented cause bits for the normal and the three-pin variant.
  localparam logic [31:0] CAUSE_MASK_BASE = 32'h0001_f680;
  localparam logic [31:0] CAUSE_MASK_VAR  = 32'h0001_fe80;

  // ========================================================================
  // Extended control fields.
  // ========================================================================
  localparam int          EXT_PHY_EN_BIT = 1;             // Physical layer enable.
  localparam int          EXT_GPI_EN_LSB = 2;             // Three pin detect enables.
  localparam logic [31:0] EXT_WMASK      = 32'h0000_001e; // Writable bits.

  // ========================================================================
  // Configuration fields and reset values.
  // ========================================================================
  localparam int          CFG_SERDES_BIT = 0;  // Internal serdes mode.
  localparam int          CFG_VAR3_BIT   = 1;  // Three-pin variant.
  localparam int          CFG_MSG_BIT    = 2;  // Interrupt as link messages.
  localparam int          SRP_W          = 12; // Size limit width.
  localparam logic [31:0] REG_RESET      = 32'h0000_0000;

  // Message sender states.
  typedef enum logic {MSG_IDLE, MSG_SEND} msg_state_t;

endpackage

// ==== src/gp_pin_detect.sv ====
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Samples the general purpose pins and raises a set request per pin.
// ==========================================================================
module gp_pin_detect (
  // Clock and reset.
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Pins and per-pin detect enables.
  input  wire logic [2:0] pin,
  input  wire logic [2:0] detect_en,
  // Set requests towards the cause register.
  output logic      [2:0] pin_set
);

  // All state of this module.
  typedef struct packed {
    logic [2:0] set;  // Registered set request.
  } gp_state_t;

  gp_state_t s;  // Current state.
  gp_state_t n;  // Next state.

  // ========================================================================
  // A pin sets its cause whenever sampled high while detection is on.
  // ========================================================================
  always_comb begin
    n = s;
    n.set = pin & detect_en;
  end

  // Register the state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign pin_set = s.set;

  // A high enabled pin is reported on the next cycle.
  pin_sample_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pin & detect_en) != 3'h0 |=> (pin_set == $past(pin & detect_en)))
    else $error("Enabled high pin not reported.");

endmodule
`default_nettype wire

// ==== src/irq_msg.sv ====
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Turns the interrupt level into assert and deassert messages on the link.
// ==========================================================================
module irq_msg (
  // Clock and reset.
  input  wire logic pclk,
  input  wire logic presetn,
  // Interrupt level to deliver.
  input  wire logic level,
  // Message port on the chipset link.
  output logic      msg_valid,
  output logic      msg_assert,
  input  wire logic msg_ready
);

  // All state of this module.
  typedef struct packed {
    icause_pkg::msg_state_t st;   // Sender state.
    logic                   sent; // Level last delivered.
    logic                   val;  // Level being delivered.
  } msg_reg_t;

  msg_reg_t s;  // Current state.
  msg_reg_t n;  // Next state.

  // ========================================================================
  // Only a change of level is sent, so the host sees alternating messages.
  // The level is held stable while a message waits, which keeps the two
  // messages from overtaking each other on a busy link.
  // ========================================================================
  always_comb begin
    n = s;
    case (s.st)
      icause_pkg::MSG_IDLE: begin
        if (level != s.sent) begin
          n.val = level;
          n.st  = icause_pkg::MSG_SEND;
        end
      end
      icause_pkg::MSG_SEND: begin
        if (msg_ready) begin
          n.sent = s.val;
          n.st   = icause_pkg::MSG_IDLE;
        end
      end
      default: begin
        n.st = icause_pkg::MSG_IDLE;
      end
    endcase
  end

  // Register the state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '{st: icause_pkg::MSG_IDLE, sent: 1'b0, val: 1'b0};
    end else begin
      s <= n;
    end
  end

  assign msg_valid  = (s.st == icause_pkg::MSG_SEND);
  assign msg_assert = s.val;

  // A waiting message keeps its value until taken.
  msg_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    msg_valid && !msg_ready |=> msg_valid && (msg_assert == $past(msg_assert)))
    else $error("Pending message changed before acceptance.");

endmodule
`default_nettype wire

// ==== tb/host_link_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Host side of the chipset link: takes interrupt messages, stalls now and then.
// ==========================================================================
module host_link_model (
  // Clock and reset.
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Message port from the device.
  input  wire logic       msg_valid,
  input  wire logic       msg_assert,
  output logic            msg_ready,
  // Interrupt level as the host understands it, and messages taken.
  output logic            host_level,
  output logic      [7:0] msg_count
);
  logic [1:0] stall_cnt;  // Free running, makes one busy cycle in four.

  // A stall makes the device hold a message, as a busy link would.
  assign msg_ready = (stall_cnt != 2'h0);

  // Each accepted message sets the host's view of the interrupt line.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stall_cnt  <= 2'h0;
      host_level <= 1'b0;
      msg_count  <= 8'h00;
    end else begin
      stall_cnt <= stall_cnt + 2'h1;
      if (msg_valid && msg_ready) begin
        host_level <= msg_assert;
        msg_count  <= msg_count + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/tb_interrupt_cause_upper_bits.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHECK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin \
  mismatches++; $display("ERROR at %0t: got %h expected %h", $time, got, exp); end end
// ==========================================================================
// Self-checking bench for the upper interrupt cause bits.
// ==========================================================================
module tb_interrupt_cause_upper_bits;
  localparam logic [11:0] cause_a = icause_pkg::CAUSE_OFF;  // Cause register.
  localparam logic [11:0] ext_a   = icause_pkg::EXT_CTRL_OFF;
  localparam logic [11:0] mask_a  = icause_pkg::MASK_OFF;
  localparam logic [11:0] srp_a   = icause_pkg::SRP_OFF;
  localparam logic [11:0] cfg_a   = icause_pkg::CFG_OFF;
  localparam int          ev_bit [4] = '{icause_pkg::RXT_BIT, icause_pkg::MGMT_ACCESS_DONE_CAUSE_BIT,
                                         icause_pkg::TXLOW_BIT, icause_pkg::SRP_BIT};
  logic        pclk      = 1'b0;
  logic        presetn   = 1'b0;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [11:0] paddr     = 12'h000;
  logic [31:0] pwdata    = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  ev        = 4'h0;      // Timer, management, ring low, packet.
  logic        cfg_word  = 1'b0;
  logic        phy_lvl   = 1'b0;
  logic [2:0]  pins      = 3'h0;
  logic [2:0]  pin_dir   = 3'h0;
  logic [15:0] pkt_len   = 16'h0040;  // Equal to the limit: the boundary case.
  logic        rx_desc_flush, irq, msg_valid, msg_assert, msg_ready, host_level;
  logic [7:0]  msg_count;
  logic [31:0] rd;
  logic        err;
  logic [31:0] lfsr_q    = 32'h0774;
  int          mismatches = 0;
  int          samples_checked = 0;
  int          flushes   = 0;

  // Clock at 125 MHz.
  always #4 pclk = ~pclk;

  // Counts flush pulses so a doubled or missing one shows.
  always @(posedge pclk) begin
    if (rx_desc_flush === 1'b1) flushes++;
  end

  interrupt_cause_upper_bits dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_timer_expire(ev[0]), .mdio_done(ev[1]),
    .rx_config_word_flag(cfg_word), .phy_irq(phy_lvl), .software_definable_pin(pins),
    .sdp_dir_in(pin_dir), .tx_ring_low(ev[2]), .rx_pkt_done(ev[3]), .rx_pkt_len(pkt_len),
    .rx_desc_flush(rx_desc_flush), .irq(irq), .msg_valid(msg_valid),
    .msg_assert(msg_assert), .msg_ready(msg_ready));

  host_link_model host (.pclk(pclk), .presetn(presetn), .msg_valid(msg_valid),
    .msg_assert(msg_assert), .msg_ready(msg_ready), .host_level(host_level),
    .msg_count(msg_count));

  // Step of the stimulus shift register.
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Read and compare.
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHECK(rd, e)
  endtask

  // One-cycle event pulse, then time for the cause and the interrupt to land.
  task automatic pulse(input int i);
    @(posedge pclk);
    ev[i] <= 1'b1;
    @(posedge pclk);
    ev[i] <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  // Bounded wait for the host to have taken n messages.
  task automatic wait_msgs(input logic [7:0] n);
    int k;
    k = 0;
    while (msg_count !== n && k < 100) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 100) begin
      mismatches++;
      wrap_up();
    end
  endtask

  // Main sequence.
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(cause_a, 32'h0);
    rd_chk(mask_a, 32'h0);
    rd_chk(12'hffc, 32'h0);
    `CHECK(err, 1'b1)
    apb(1'b1, srp_a, 32'h0000_0040);
    for (int i = 0; i < 4; i++) begin
      pulse(i);
      rd_chk(cause_a, 32'h1 << ev_bit[i]);
      rd_chk(cause_a, 32'h0);
    end
    `CHECK(flushes, 1)
    pkt_len <= 16'h0041;
    pulse(3);
    rd_chk(cause_a, 32'h0);
    apb(1'b1, srp_a, 32'h0);
    pkt_len <= 16'h0000;
    pulse(3);
    rd_chk(cause_a, 32'h0);
    phy_lvl <= 1'b1;
    cfg_word <= 1'b1;
    rd_chk(cause_a, 32'h0);
    apb(1'b1, ext_a, 32'h0000_000e);
    rd_chk(ext_a, 32'h0000_000e);
    apb(1'b1, cfg_a, 32'h1);
    // The mode bit is only live after the write edge, so keep the flag up one more cycle.
    @(posedge pclk);
    phy_lvl <= 1'b0;
    cfg_word <= 1'b0;
    rd_chk(cause_a, 32'h0000_1400);
    pins <= 3'b011;
    repeat (4) @(posedge pclk);
    pins <= 3'b000;
    rd_chk(cause_a, 32'h0000_6000);
    apb(1'b1, cfg_a, 32'h2);
    apb(1'b1, ext_a, 32'h0000_001c);
    pin_dir <= 3'b111;
    pins <= 3'b100;
    repeat (4) @(posedge pclk);
    pins <= 3'b000;
    rd_chk(cause_a, 32'h0000_0800);
    rd_chk(cause_a, 32'h0);
    apb(1'b1, mask_a, 32'h0000_0600);
    pulse(1);
    `CHECK(irq, 1'b1)
    rd_chk(cause_a, 32'h0000_0200);
    repeat (2) @(posedge pclk);
    `CHECK(irq, 1'b0)
    for (int j = 0; j < 4; j++) begin
      lfsr_q = lfsr_next(lfsr_q);
      pulse(1);
      pulse(2);
      apb(1'b1, cause_a, lfsr_q & icause_pkg::CAUSE_MASK_BASE);
      rd_chk(cause_a, 32'h0000_8200 & ~lfsr_q);
    end
    apb(1'b1, mask_a, 32'h0000_0080);
    apb(1'b1, cfg_a, 32'h4);
    pulse(0);
    wait_msgs(8'h01);
    `CHECK(host_level, 1'b1)
    `CHECK(irq, 1'b0)
    rd_chk(cause_a, 32'h0000_0080);
    wait_msgs(8'h02);
    `CHECK(host_level, 1'b0)
    wrap_up();
  end
endmodule
`default_nettype wire
